// File: shared/sos_defs.svh
/*
 Offsets, field positions, reset values and timing of the supervisor.
 Assumes a 100 MHz clock.
*/
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH
// Clock and time base
`define SOS_CLK_PERIOD_NS 10
`define SOS_MS_NS 1000000
`define SOS_MS_CYC (`SOS_MS_NS / `SOS_CLK_PERIOD_NS)
// Register byte offsets
`define SOS_REG_CTRL 8'h00
`define SOS_REG_RDELAY 8'h04
`define SOS_REG_INDELAY 8'h08
`define SOS_REG_PPC 8'h0C
`define SOS_REG_TOL 8'h10
`define SOS_REG_SUCC 8'h14
`define SOS_REG_STAT 8'h18
// Control field positions
`define SOS_CTRL_MODE_LSB 0
`define SOS_CTRL_EDM 2
`define SOS_CTRL_ONEHOT 3
`define SOS_CTRL_CLR 4
`define SOS_CTRL_POL_RREQ 5
`define SOS_CTRL_POL_MON 6
// Successor write field positions
`define SOS_SUCC_IDX_LSB 8
`define SOS_SUCC_DATA_LSB 0
// Reset values
`define SOS_CTRL_RST 32'h0000_0000
`define SOS_RDELAY_RST 32'h0000_03E8
`define SOS_INDELAY_RST 32'h0000_000C
`define SOS_PPC_RST 32'h0064_0064
`define SOS_TOL_RST 32'h0000_000A
// Timing figures
`define SOS_SPEED_WIN_MS 100
`define SOS_SPEED_LO_CMS 10
`define SOS_SPEED_HI_CMS 30
`define SOS_SLOW_LIMIT_S 60
`define SOS_FAST_LIMIT_S 20
`define SOS_DIR_LIMIT_MS 400
`define SOS_EDM_CHECK_MS 10
`define SOS_PCT_FULL 100
`endif

// File: shared/sos_pkg.sv
/*
 Types of the supervisor: modes, states, successors, status. No assumptions.
*/
package sos_pkg;
   typedef enum logic [1:0] {
      SOS_RM_IMMEDIATE = 2'h0,
      SOS_RM_RESET = 2'h1,
      SOS_RM_DELAYED = 2'h2
   } sos_mode_t;
   typedef enum logic [3:0] {
      SOS_ST_OFF = 4'h1,
      SOS_ST_DELAY = 4'h2,
      SOS_ST_ON = 4'h4,
      SOS_ST_LOCK = 4'h8
   } sos_state_t;
   // Up to two permitted following cases, each with its own valid bit
   typedef struct packed {
      logic v1;
      logic [2:0] c1;
      logic v0;
      logic [2:0] c0;
   } sos_succ_t;
   typedef struct packed {
      logic lock;
      logic seq_fault;
      logic plaus_fault;
      logic case_valid;
      logic [2:0] case_idx;
   } sos_stat_t;
endpackage

// File: rtl/sos_succ_mem.sv
/*
 Successor table, one entry per case; registered read. Single clock.
*/
`timescale 1ns/1ps
module sos_succ_mem #(
   parameter int DEPTH = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_we,
   input wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input wire sos_pkg::sos_succ_t i_wdata,
   input wire logic [$clog2(DEPTH)-1:0] i_raddr,
   output sos_pkg::sos_succ_t o_rdata
);
   import sos_pkg::*;
   sos_succ_t mem_reg [DEPTH];
   sos_succ_t rd_reg;
   assign o_rdata = rd_reg;
   // Table storage; an empty entry allows any following case
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_reg <= '0;
         for (int k = 0; k < DEPTH; k++) begin
            mem_reg[k] <= '0;
         end
      end else begin
         if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
         end
         rd_reg <= mem_reg[i_raddr];
      end
   end
endmodule // sos_succ_mem

// File: rtl/sos_top.sv
/*
 Safety output supervisor: restart handling, contactor feedback check,
 status polarity, two-encoder plausibility, input settling and case order.
 Assumes pins are asynchronous, i_field_obj comes from same-clock logic.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
// How it works
// - Immediate mode: on when field clears
// - Reset mode: on only after reset input
// - Delayed mode: on after clear delay
// - After switch-off, sample contactor feedback
// - Missing feedback locks, outputs stay off
// - Status outputs follow per-output polarity setting; here only o_reset_req and o_monitor, o_status has none
// - Each encoder has own pulses per distance
// - Tolerance is percent of larger magnitude
// - Larger speed is the effective speed
// - Below 10 cm/s no disagreement shutoff
// - 10 to 30 cm/s: 60 s excess
// - At 30 cm/s and above: 20 s
// - Opposite directions tolerated 0.4 s only
// - Expired allowance switches outputs off
// - Up to two successors per case
// - Empty successor list allows any case
// - Case outside successor list switches off
// - Complementary pairs must be inverse
// - One-hot needs exactly one active channel
`timescale 1ns/1ps
`include "sos_defs.svh"
module sos_top #(
   parameter int MS_CYC = `SOS_MS_CYC,
   parameter int N_CASE = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_field_obj,
   input wire logic [7:0] i_ctrl_in,
   input wire logic i_reset_btn,
   input wire logic i_contactor_fb,
   input wire logic [1:0] i_enc_pulse,
   input wire logic [1:0] i_enc_dir,
   output logic [1:0] o_safety_switch_out_pair,
   output logic o_reset_req,
   output logic o_monitor,
   output sos_pkg::sos_stat_t o_status
);
   import sos_pkg::*;
   localparam logic [19:0] MS_LAST = 20'(MS_CYC - 1);
   localparam logic [15:0] SLOW_MS = 16'(`SOS_SLOW_LIMIT_S * 1000);
   localparam logic [15:0] FAST_MS = 16'(`SOS_FAST_LIMIT_S * 1000);
   localparam logic [15:0] DIR_MS = 16'(`SOS_DIR_LIMIT_MS);
   localparam logic [15:0] EDM_MS = 16'(`SOS_EDM_CHECK_MS);
   localparam logic [15:0] WIN_MS = 16'(`SOS_SPEED_WIN_MS);
   localparam logic [3:0] LO_F = 4'(`SOS_SPEED_LO_CMS * `SOS_SPEED_WIN_MS / 1000);
   localparam logic [3:0] HI_F = 4'(`SOS_SPEED_HI_CMS * `SOS_SPEED_WIN_MS / 1000);

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            old[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return old;
   endfunction
   // Saturating millisecond counter step
   function automatic logic [15:0] ms_step(input logic [15:0] v, input logic run, input logic tick);
      return !run ? 16'h0000 : (tick && v != 16'hFFFF) ? v + 16'h0001 : v;
   endfunction

   // Two-flop synchronisers for all pins, third stage for edges
   logic [13:0] s1_reg, s2_reg, s3_reg;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= {i_enc_dir, i_enc_pulse, i_contactor_fb, i_reset_btn, i_ctrl_in};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   logic [7:0] ctrl_s;
   logic rbtn_rise, fb_s;
   logic [1:0] pls_rise, dir_s;
   assign ctrl_s = s2_reg[7:0];
   assign rbtn_rise = s2_reg[8] & ~s3_reg[8];
   assign fb_s = s2_reg[9];
   assign pls_rise = s2_reg[11:10] & ~s3_reg[11:10];
   assign dir_s = s2_reg[13:12];

   // Register file and AXI4-Lite slave
   logic [31:0] ctrl_reg, ctrl_next, rdly_reg, rdly_next, indly_reg, indly_next;
   logic [31:0] ppc_reg, ppc_next, tol_reg, tol_next, rdata_reg, rdata_next;
   logic [7:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next;
   logic [3:0] ws_reg, ws_next;
   logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic succ_we;
   logic [31:0] stat_word;
   sos_stat_t stat_reg, stat_next;
   always_comb begin
      ctrl_next = ctrl_reg;
      ctrl_next[`SOS_CTRL_CLR] = 1'b0;
      rdly_next = rdly_reg;
      indly_next = indly_reg;
      ppc_next = ppc_reg;
      tol_next = tol_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      ws_next = ws_reg;
      aw_next = aw_reg;
      w_next = w_reg;
      bv_next = bv_reg;
      bresp_next = bresp_reg;
      rv_next = rv_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      succ_we = 1'b0;
      if (i_s_axi_awvalid && !aw_reg && !bv_reg) begin
         aw_next = 1'b1;
         awa_next = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && !w_reg && !bv_reg) begin
         w_next = 1'b1;
         wd_next = i_s_axi_wdata;
         ws_next = i_s_axi_wstrb;
      end
      if (aw_reg && w_reg) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         bresp_next = 2'h0;
         unique case ({awa_reg[7:2], 2'h0})
            `SOS_REG_CTRL: ctrl_next = merge(ctrl_reg, wd_reg, ws_reg);
            `SOS_REG_RDELAY: rdly_next = merge(rdly_reg, wd_reg, ws_reg);
            `SOS_REG_INDELAY: indly_next = merge(indly_reg, wd_reg, ws_reg);
            `SOS_REG_PPC: ppc_next = merge(ppc_reg, wd_reg, ws_reg);
            `SOS_REG_TOL: tol_next = merge(tol_reg, wd_reg, ws_reg);
            `SOS_REG_SUCC: succ_we = 1'b1;
            `SOS_REG_STAT: ;
            default: bresp_next = 2'h2;
         endcase
      end
      if (bv_reg && i_s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (i_s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1;
         rresp_next = 2'h0;
         unique case ({i_s_axi_araddr[7:2], 2'h0})
            `SOS_REG_CTRL: rdata_next = ctrl_reg;
            `SOS_REG_RDELAY: rdata_next = rdly_reg;
            `SOS_REG_INDELAY: rdata_next = indly_reg;
            `SOS_REG_PPC: rdata_next = ppc_reg;
            `SOS_REG_TOL: rdata_next = tol_reg;
            `SOS_REG_SUCC: rdata_next = 32'h0000_0000;
            `SOS_REG_STAT: rdata_next = stat_word;
            default: begin
               rdata_next = 32'h0000_0000;
               rresp_next = 2'h2;
            end
         endcase
      end else if (rv_reg && i_s_axi_rready) begin
         rv_next = 1'b0;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_reg <= `SOS_CTRL_RST;
         rdly_reg <= `SOS_RDELAY_RST;
         indly_reg <= `SOS_INDELAY_RST;
         ppc_reg <= `SOS_PPC_RST;
         tol_reg <= `SOS_TOL_RST;
         {awa_reg, wd_reg, ws_reg, aw_reg, w_reg, bv_reg, rv_reg} <= '0;
         {bresp_reg, rresp_reg, rdata_reg} <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         rdly_reg <= rdly_next;
         indly_reg <= indly_next;
         ppc_reg <= ppc_next;
         tol_reg <= tol_next;
         {awa_reg, wd_reg, ws_reg, aw_reg, w_reg, bv_reg, rv_reg} <=
            {awa_next, wd_next, ws_next, aw_next, w_next, bv_next, rv_next};
         {bresp_reg, rresp_reg, rdata_reg} <= {bresp_next, rresp_next, rdata_next};
      end
   end
   assign o_s_axi_awready = !aw_reg && !bv_reg;
   assign o_s_axi_wready = !w_reg && !bv_reg;
   assign o_s_axi_bvalid = bv_reg;
   assign o_s_axi_bresp = bresp_reg;
   assign o_s_axi_arready = !rv_reg;
   assign o_s_axi_rvalid = rv_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;

   sos_mode_t mode;
   logic clr;
   assign mode = sos_mode_t'(ctrl_reg[`SOS_CTRL_MODE_LSB +: 2]);
   assign clr = ctrl_reg[`SOS_CTRL_CLR];

   // Millisecond tick divider
   logic [19:0] div_reg, div_next;
   logic tick;
   assign tick = (div_reg == MS_LAST);
   always_comb begin
      div_next = tick ? 20'h00000 : div_reg + 20'h00001;
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   // Case decode, settling delay and successor check
   logic [2:0] dec_case, cand_reg, cand_next, case_reg, case_next;
   logic dec_valid, cvalid_reg, cvalid_next, seqf_reg, seqf_next;
   logic [15:0] stab_reg, stab_next;
   sos_succ_t succ;
   logic succ_ok;
   always_comb begin
      dec_case = 3'h0;
      dec_valid = 1'b0;
      if (ctrl_reg[`SOS_CTRL_ONEHOT]) begin
         dec_valid = ($countones(ctrl_s) == 1);
         for (int k = 0; k < 8; k++) begin
            if (ctrl_s[k]) begin
               dec_case = 3'(k);
            end
         end
      end else begin
         dec_valid = ((ctrl_s[2:0] ^ ctrl_s[6:4]) == 3'h7);
         dec_case = ctrl_s[2:0];
      end
      succ_ok = (!succ.v0 && !succ.v1)
         || (succ.v0 && succ.c0 == cand_reg) || (succ.v1 && succ.c1 == cand_reg);
      cand_next = {dec_valid, dec_case} != {1'b1, cand_reg} ? dec_case : cand_reg;
      stab_next = ({dec_valid, dec_case} != {1'b1, cand_reg}) ? 16'h0000 : ms_step(stab_reg, 1'b1, tick);
      case_next = case_reg;
      cvalid_next = cvalid_reg;
      seqf_next = seqf_reg && !clr;
      if (!dec_valid) begin
         cvalid_next = 1'b0;
      end else if ({1'b1, cand_reg} == {dec_valid, dec_case} && stab_reg >= indly_reg[15:0]
                   && (!cvalid_reg || case_reg != cand_reg)) begin
         if (cvalid_reg && !succ_ok) begin
            seqf_next = 1'b1;
         end
         case_next = cand_reg;
         cvalid_next = 1'b1;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {cand_reg, case_reg, cvalid_reg, seqf_reg, stab_reg} <= '0;
      end else begin
         {cand_reg, case_reg, cvalid_reg, seqf_reg, stab_reg} <=
            {cand_next, case_next, cvalid_next, seqf_next, stab_next};
      end
   end
   sos_succ_mem #(.DEPTH(N_CASE)) u_succ (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_we(succ_we),
      .i_waddr(wd_reg[`SOS_SUCC_IDX_LSB +: 3]),
      .i_wdata(sos_succ_t'(wd_reg[`SOS_SUCC_DATA_LSB +: 8])),
      .i_raddr(case_reg),
      .o_rdata(succ)
   );

   // Encoder speed, tolerance and direction plausibility
   logic [15:0] cnt_reg [2], cnt_next [2], spd_reg [2], spd_next [2];
   logic [1:0] dir_reg, dir_next, sdir_reg, sdir_next;
   logic [15:0] win_reg, win_next, tolt_reg, tolt_next, dirt_reg, dirt_next;
   logic plf_reg, plf_next;
   logic [31:0] na, nb, eff, diff, base;
   logic lo, hi, exceed, dirmis;
   always_comb begin
      na = spd_reg[0] * ppc_reg[31:16];
      nb = spd_reg[1] * ppc_reg[15:0];
      eff = (na > nb) ? na : nb;
      diff = (na > nb) ? na - nb : nb - na;
      base = ppc_reg[15:0] * ppc_reg[31:16];
      lo = (eff >= 32'(base * LO_F));
      hi = (eff >= 32'(base * HI_F));
      exceed = (48'(diff) * 48'(`SOS_PCT_FULL)) > (48'(eff) * 48'(tol_reg[7:0]));
      dirmis = (sdir_reg[0] != sdir_reg[1]) && lo;
      win_next = ms_step(win_reg, 1'b1, tick);
      for (int e = 0; e < 2; e++) begin
         cnt_next[e] = cnt_reg[e] + 16'(pls_rise[e] && cnt_reg[e] != 16'hFFFF);
         dir_next[e] = pls_rise[e] ? dir_s[e] : dir_reg[e];
         spd_next[e] = spd_reg[e];
      end
      sdir_next = sdir_reg;
      if (win_reg >= WIN_MS) begin
         win_next = 16'h0000;
         for (int e = 0; e < 2; e++) begin
            spd_next[e] = cnt_reg[e];
            cnt_next[e] = 16'(pls_rise[e]);
         end
         sdir_next = dir_reg;
      end
      tolt_next = ms_step(tolt_reg, exceed && lo, tick);
      dirt_next = ms_step(dirt_reg, dirmis, tick);
      plf_next = plf_reg && !clr;
      if (tolt_reg >= (hi ? FAST_MS : SLOW_MS) || dirt_reg >= DIR_MS) begin
         plf_next = 1'b1;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_reg <= '{default: 16'h0000};
         spd_reg <= '{default: 16'h0000};
         {dir_reg, sdir_reg, win_reg, tolt_reg, dirt_reg, plf_reg} <= '0;
      end else begin
         cnt_reg <= cnt_next;
         spd_reg <= spd_next;
         {dir_reg, sdir_reg, win_reg, tolt_reg, dirt_reg, plf_reg} <=
            {dir_next, sdir_next, win_next, tolt_next, dirt_next, plf_next};
      end
   end

   // Output pair state machine with restart and feedback check
   sos_state_t st_reg, st_next;
   logic [15:0] t_reg, t_next;
   logic chk_reg, chk_next, rreq;
   logic [1:0] pair_reg, pair_next;
   logic rreq_reg, rreq_next, mon_reg, mon_next;
   logic go;
   always_comb begin
      go = cvalid_reg && !seqf_reg && !plf_reg && !i_field_obj;
      st_next = st_reg;
      t_next = ms_step(t_reg, 1'b1, tick);
      chk_next = chk_reg;
      rreq = 1'b0;
      if (chk_reg && t_reg >= EDM_MS) begin
         chk_next = 1'b0;
         if (!fb_s) begin
            st_next = SOS_ST_LOCK;
         end
      end
      unique case (st_reg)
         SOS_ST_OFF: begin
            rreq = go && mode == SOS_RM_RESET;
            if (go && !chk_reg) begin
               if (mode == SOS_RM_IMMEDIATE) begin
                  st_next = SOS_ST_ON;
               end else if (mode == SOS_RM_RESET && rbtn_rise) begin
                  st_next = SOS_ST_ON;
               end else if (mode == SOS_RM_DELAYED) begin
                  st_next = SOS_ST_DELAY;
                  t_next = 16'h0000;
               end
            end
         end
         SOS_ST_DELAY: begin
            if (!go) begin
               st_next = SOS_ST_OFF;
            end else if (t_reg >= rdly_reg[15:0]) begin
               st_next = SOS_ST_ON;
            end
         end
         SOS_ST_ON: begin
            if (!go) begin
               st_next = SOS_ST_OFF;
               t_next = 16'h0000;
               chk_next = ctrl_reg[`SOS_CTRL_EDM];
            end
         end
         SOS_ST_LOCK: begin
            chk_next = 1'b0;
            if (clr) begin
               st_next = SOS_ST_OFF;
            end
         end
      endcase
      pair_next = (st_next == SOS_ST_ON) ? 2'h3 : 2'h0;
      rreq_next = rreq ^ ctrl_reg[`SOS_CTRL_POL_RREQ];
      mon_next = i_field_obj ^ ctrl_reg[`SOS_CTRL_POL_MON];
      stat_next = '{lock: st_reg == SOS_ST_LOCK, seq_fault: seqf_reg, plaus_fault: plf_reg,
                    case_valid: cvalid_reg, case_idx: case_reg};
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_reg <= SOS_ST_OFF;
         {t_reg, chk_reg, pair_reg, rreq_reg, mon_reg} <= '0;
         stat_reg <= '0;
      end else begin
         st_reg <= st_next;
         {t_reg, chk_reg, pair_reg, rreq_reg, mon_reg} <= {t_next, chk_next, pair_next, rreq_next, mon_next};
         stat_reg <= stat_next;
      end
   end
   assign stat_word = {24'h000000, st_reg, 1'b0, stat_reg.lock, stat_reg.seq_fault, stat_reg.plaus_fault};
   assign o_safety_switch_out_pair = pair_reg;
   assign o_reset_req = rreq_reg;
   assign o_monitor = mon_reg;
   assign o_status = stat_reg;
endmodule // sos_top

// File: dv/sos_chk.sv
/* Port checker for the safety output supervisor.
 Assumes a bind from the bench top and one clock. */
`timescale 1ns/1ps
module sos_chk (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_field_obj,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_rready,
   input wire logic o_s_axi_bvalid,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_rvalid,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic [1:0] o_safety_switch_out_pair,
   input wire logic o_monitor,
   input wire sos_pkg::sos_stat_t o_status
);
   import sos_pkg::*;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // Both channels move together, and stay off without a valid case
   property p_pair_both; o_safety_switch_out_pair inside {2'h0, 2'h3}; endproperty
   a_pair_both: assert property (p_pair_both) else $error("pair channels differ");
   property p_off_inval; !o_status.case_valid [*2] |-> !o_safety_switch_out_pair; endproperty
   a_off_inval: assert property (p_off_inval) else $error("pair on without case");
   property p_on_clear; $rose(o_safety_switch_out_pair[0]) |-> !$past(i_field_obj); endproperty
   a_on_clear: assert property (p_on_clear) else $error("pair on with object");
   // Latched faults hold the pair off
   property p_lock_off; o_status.lock [*2] |-> !o_safety_switch_out_pair; endproperty
   a_lock_off: assert property (p_lock_off) else $error("pair on while locked");
   property p_seq_off; o_status.seq_fault [*2] |-> !o_safety_switch_out_pair; endproperty
   a_seq_off: assert property (p_seq_off) else $error("pair on after order fault");
   property p_pl_off; o_status.plaus_fault [*2] |-> !o_safety_switch_out_pair; endproperty
   a_pl_off: assert property (p_pl_off) else $error("pair on after encoder fault");
   // Field status follows the field one cycle later
   property p_mon; $changed(i_field_obj) |=> $changed(o_monitor); endproperty
   a_mon: assert property (p_mon) else $error("field status not following");
   // Bus answers stand until taken
   property p_b_hold; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   c_on: cover property ($rose(o_safety_switch_out_pair[0]));
   c_lock: cover property ($rose(o_status.lock));
   c_seq: cover property ($rose(o_status.seq_fault));
   c_pl: cover property ($rose(o_status.plaus_fault));
endmodule // sos_chk

// File: dv/sos_partner.sv
/* Far side model: controller pins, two encoders, contactor contacts.
 Assumes the bench sets the wanted case, pulse periods and faults. */
`timescale 1ns/1ps
module sos_partner (
   input wire logic i_ref_clk,
   input wire logic [2:0] i_case,
   input wire logic i_bad,
   input wire logic i_stuck,
   input wire logic i_opp,
   input wire logic [1:0] i_pair,
   input wire logic [15:0] i_per_a,
   input wire logic [15:0] i_per_b,
   output logic [7:0] o_ctrl_in,
   output logic o_fb,
   output logic [1:0] o_pulse,
   output logic [1:0] o_dir
);
   logic [2:0] shown = 3'h0;
   logic [2:0] d;
   logic [15:0] ca = 16'h0, cb = 16'h0;
   // Controller settles one pair per cycle, well inside the input delay
   always @(posedge i_ref_clk) begin
      d = shown ^ i_case;
      shown <= shown ^ (d & (~d + 3'h1));
      ca <= (ca + 16'h1 >= i_per_a) ? 16'h0 : ca + 16'h1;
      cb <= (cb + 16'h1 >= i_per_b) ? 16'h0 : cb + 16'h1;
   end
   // Inverse pairs, or all low when the bench asks for a bad input
   assign o_ctrl_in = i_bad ? 8'h00 : {1'b0, ~shown, 1'b0, shown};
   assign o_pulse = {i_per_b != 0 && cb < i_per_b / 2, i_per_a != 0 && ca < i_per_a / 2};
   assign o_dir = {~i_opp, 1'b1};
   // Guided contacts close when the contactor drops, unless welded
   assign o_fb = i_pair == 2'h0 && !i_stuck;
endmodule // sos_partner

// File: dv/sos_top_tb.sv
/* Bench for the supervisor: bus master, queued answers, far side model.
 Assumes 10 cycles per millisecond in the design. */
`timescale 1ns/1ps
module sos_top_tb;
   import sos_pkg::*;
   logic clk = 0, rst_n = 0, fld = 0, btn = 0, stuck = 0, opp = 0, bad = 1;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   logic [2:0] cs = 0;
   logic [15:0] pa = 0, pb = 0;
   integer seed = 32'hf671;
   int n_errors = 0, compares = 0, cyc = 0;
   logic [33:0] qr[$];
   logic [1:0] qb[$];
   logic [7:0] rb;
   logic [31:0] rv0[6] = '{32'h0, 32'h3E8, 32'hC, 32'h0064_0064, 32'hA, 32'h0};
   logic awr, wr_, bv, arr, rv, fb, rreq, mon;
   logic [1:0] bresp, rresp, pair, pls, dir;
   logic [31:0] rdat;
   logic [7:0] cin;
   sos_stat_t st;
   sos_top #(.MS_CYC(10)) sos_top_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .i_s_axi_awaddr(awa),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
      .i_field_obj(fld), .i_ctrl_in(cin), .i_reset_btn(btn), .i_contactor_fb(fb), .i_enc_pulse(pls),
      .i_enc_dir(dir), .o_safety_switch_out_pair(pair), .o_reset_req(rreq), .o_monitor(mon), .o_status(st));
   sos_partner sos_partner_inst (.i_ref_clk(clk), .i_case(cs), .i_bad(bad), .i_stuck(stuck), .i_opp(opp),
      .i_pair(pair), .i_per_a(pa), .i_per_b(pb), .o_ctrl_in(cin), .o_fb(fb), .o_pulse(pls), .o_dir(dir));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic finish_test();
      $display("Compares %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      logic ta = 0, tw = 0;
      qb.push_back(r);
      @(posedge clk);
      {awa, wd, awv, wv} <= {a, d, 2'h3};
      while (!(ta && tw)) begin
         @(negedge clk);
         ta |= awv & awr;
         tw |= wv & wr_;
         @(posedge clk);
         awv <= !ta;
         wv <= !tw;
      end
      do @(negedge clk); while (!bv);
      @(posedge clk) br <= 1;
      @(posedge clk) br <= 0;
   endtask
   // Bus read, expectation queued for the answer watcher
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic t = 0;
      qr.push_back(e);
      @(posedge clk);
      {ara, arv} <= {a, 1'b1};
      while (!t) begin
         @(negedge clk);
         t = arr;
         @(posedge clk);
         arv <= !t;
      end
      do @(negedge clk); while (!rv);
      @(posedge clk) rr <= 1;
      @(posedge clk) rr <= 0;
   endtask
   // Answer watcher and hang limit
   always @(negedge clk) begin
      if (rv && rr) chk("rdata", {rresp, rdat}, qr.pop_front());
      if (bv && br) chk("bresp", 34'(bresp), 34'(qb.pop_front()));
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      foreach (rv0[i]) rd(8'(4 * i), {2'h0, rv0[i]});
      rd(8'h1C, {2'h2, 32'h0});
      wr(8'h1C, 32'h1, 2'h2);
      rb = $random(seed);
      wr(8'h10, {24'h0, rb});
      rd(8'h10, {26'h0, rb});
      cy(300);
      chk("pair", pair, 2'h0);
      chk("valid", st.case_valid, 1'b0);
      rd(8'h18, 34'h10);
      @(posedge clk) bad <= 0;
      cy(200);
      chk("pair", pair, 2'h3);
      @(posedge clk) fld <= 1;
      cy(3);
      chk("mon", mon, 1'b1);
      wr(8'h00, 32'h60);
      cy(2);
      chk("mon", mon, 1'b0);
      chk("rreq", rreq, 1'b1);
      wr(8'h00, 32'h1);
      @(posedge clk) fld <= 0;
      cy(20);
      chk("pair", pair, 2'h0);
      chk("rreq", rreq, 1'b1);
      @(posedge clk) btn <= 1;
      cy(4);
      @(posedge clk) btn <= 0;
      cy(6);
      chk("pair", pair, 2'h3);
      wr(8'h04, 32'hA);
      wr(8'h00, 32'h2);
      @(posedge clk) fld <= 1;
      cy(3);
      @(posedge clk) fld <= 0;
      cy(60);
      chk("pair", pair, 2'h0);
      cy(70);
      chk("pair", pair, 2'h3);
      wr(8'h00, 32'h4);
      @(posedge clk) fld <= 1;
      cy(150);
      rd(8'h18, 34'h10);
      @(posedge clk) fld <= 0;
      cy(5);
      chk("pair", pair, 2'h3);
      stuck <= 1;
      @(posedge clk) fld <= 1;
      cy(150);
      @(posedge clk) fld <= 0;
      cy(20);
      chk("pair", pair, 2'h0);
      rd(8'h18, 34'h84);
      stuck <= 0;
      wr(8'h00, 32'h10);
      cy(5);
      chk("pair", pair, 2'h3);
      wr(8'h14, 32'hA9);
      @(posedge clk) cs <= 2;
      cy(200);
      chk("pair", pair, 2'h3);
      @(posedge clk) cs <= 5;
      cy(200);
      chk("pair", pair, 2'h3);
      wr(8'h14, 32'h508);
      @(posedge clk) cs <= 3;
      cy(200);
      chk("pair", pair, 2'h0);
      rd(8'h18, 34'h12);
      @(posedge clk) cs <= 5;
      cy(200);
      wr(8'h00, 32'h10);
      @(posedge clk) opp <= 1;
      pa <= 40;
      pb <= 40;
      cy(8000);
      chk("pair", pair, 2'h3);
      @(posedge clk) pa <= 4;
      pb <= 4;
      cy(3000);
      chk("pair", pair, 2'h3);
      cy(4000);
      chk("pair", pair, 2'h0);
      rd(8'h18, 34'h11);
      finish_test();
   end
endmodule // sos_top_tb
bind sos_top sos_chk sos_chk_inst (.*);
